// ==== utx_top.sv ====
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Idle flag clears after status read, data write
// - Idle flag stays low while work queued
// - Empty flag sets when shifter takes character
// - Empty flag clears after status read, data write
// - Transmitter disable also sets empty flag
// - Port disabled floats both serial pins
// - Enabled transmit pin follows enable bits; shared pin also single-wire bit
// - Disable empties buffer, resets baud counter
// - Disable clears enables, break, receive flags
// - Disable keeps all other configuration bits
// - Disable while active aborts all transfers
// - Length bit selects 8 or 9 bits
// - Parity bit never copied into data holders
// - Parity enable replaces top data bit
// - Parity type even, odd, mark, space
// - Break holds line low thirteen bits minimum
// - Receive ninth read-only, transmit ninth write-only
// - Transmitter disable aborts, resets, floats pin
// - Drive transmit pin only when both enabled
// - Idle sets when empty and nothing sending
// - Shift out least significant bit first
// - Enabled idle or empty flags request interrupt
module utx_top
    import utx_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire utx_rx_report_type rx_report,
    input wire logic rx_active,
    input wire logic shared_line_in,
    output utx_pin_drive_type tx_pin,
    output utx_pin_drive_type shared_line_pin,
    output logic rx_line,
    output logic receiver_enable,
    output logic single_wire_select,
    output logic [15:0] baud_divisor,
    output logic [5:0] fifo_control,
    output logic irq_request
);

    // Control and configuration registers
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic swm_reg;
    logic [7:0] div_hi_reg;
    logic [7:0] div_lo_reg;
    logic [5:0] fifo_ctrl_reg;
    // Transmit path state
    logic [7:0] tx_data_reg;
    logic data_full_reg;
    utx_state_type state_reg;
    utx_state_type state_next;
    logic [11:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [3:0] brk_cnt_reg;
    logic [15:0] baud_cnt_reg;
    logic tx_line_reg;
    // Transmit flags and their read-sequence arms
    logic tx_empty_reg;
    logic tx_idle_reg;
    logic empty_armed_reg;
    logic idle_armed_reg;
    // Receive-side status held here
    logic [7:0] rx_data_reg;
    logic rx_ninth_reg;
    logic rx_avail_reg;
    logic overrun_reg;
    logic perr_reg;
    logic ferr_reg;
    logic noise_reg;
    logic rx_idle_reg;
    logic [2:0] rx_count_reg;
    logic rx_armed_reg;
    logic [7:0] rdata_reg;

    // Register port decode
    wire wr_ctrl1 = wr && (addr == ADDR_CTRL1);
    wire wr_ctrl2 = wr && (addr == ADDR_CTRL2);
    wire data_wr = wr && (addr == ADDR_DATA);
    wire data_rd = rd && (addr == ADDR_DATA);
    wire status_rd = rd && (addr == ADDR_STATUS);

    // Enables
    wire port_on = ctrl1_reg[C1_PORT_EN];
    wire tx_on = port_on && ctrl2_reg[C2_TX_EN];
    wire rx_on = port_on && ctrl2_reg[C2_RX_EN];
    wire nine_bits = ctrl1_reg[C1_DATA_LEN];
    wire par_en = ctrl1_reg[C1_PAR_EN];
    wire [1:0] par_kind = {ctrl1_reg[C1_PAR_HI], ctrl1_reg[C1_PAR_LO]};

    // Control writes; disable clears only break and the two enables
    wire [7:0] ctrl1_written = wr_ctrl1 ? (wdata & CTRL1_WRITE_MASK) : ctrl1_reg;
    wire [7:0] ctrl1_next = ctrl1_written[C1_PORT_EN] ? ctrl1_written
                                                       : (ctrl1_written & ~CTRL1_BREAK_MASK);
    wire [7:0] ctrl2_written = wr_ctrl2 ? wdata : ctrl2_reg;
    wire [7:0] ctrl2_next = port_on ? ctrl2_written
                                    : (ctrl2_written & ~CTRL2_DISABLE_MASK);

    // Baud generator: divisor is cycles per bit, restarts when idle or disabled
    wire [15:0] divisor = {div_hi_reg, div_lo_reg};
    wire baud_last = (divisor <= 16'h0001) || (baud_cnt_reg == divisor - 16'h0001);
    wire baud_hold = !port_on || (state_reg == TX_IDLE);
    wire [15:0] baud_cnt_next = (baud_hold || baud_last) ? 16'h0000
                                                         : baud_cnt_reg + 16'h0001;
    wire tick = baud_last && !baud_hold;

    // Shifter takes the buffered character only when idle
    wire load = (state_reg == TX_IDLE) && data_full_reg && tx_on;
    wire data_full_next = !tx_on ? 1'b0 : data_wr ? 1'b1 : load ? 1'b0 : data_full_reg;

    // Top frame bit: parity, ninth bit or data bit 7
    wire par9 = utx_parity(tx_data_reg, par_kind);
    wire par8 = utx_parity({1'b0, tx_data_reg[6:0]}, par_kind);
    wire top9 = par_en ? par9 : ctrl1_reg[C1_TX_NINTH];
    wire top8 = par_en ? par8 : tx_data_reg[7];
    wire [8:0] payload = nine_bits ? {top9, tx_data_reg}
                                   : {1'b1, top8, tx_data_reg[6:0]};
    wire [11:0] frame = {2'b11, payload, 1'b0};
    wire [3:0] frame_len = nine_bits ? FRAME_BITS_9 : FRAME_BITS_8;

    // Flag updates: hardware set wins over the software clear
    wire empty_set = load || !tx_on;
    wire empty_clr = data_wr && empty_armed_reg;
    wire tx_empty_next = empty_set || (tx_empty_reg && !empty_clr);
    wire idle_cond = !port_on || (tx_empty_next && (state_next == TX_IDLE)
                     && !data_full_next && !ctrl1_next[C1_BREAK]);
    wire idle_clr = data_wr && idle_armed_reg;
    wire tx_idle_next = idle_cond || (tx_idle_reg && !idle_clr);

    // Receive flags: set by a report, cleared by status read then data access
    wire rx_store = rx_on && rx_report.valid && !rx_avail_reg;
    wire rx_over = rx_on && rx_report.valid && rx_avail_reg;
    wire rx_clr = rx_armed_reg && (data_rd || data_wr);
    wire [7:0] rx_byte = (par_en && !nine_bits) ? {1'b0, rx_report.bits[6:0]}
                                                 : rx_report.bits[7:0];
    wire rx_ninth_take = rx_store && nine_bits && !par_en;

    // Transmit sequencer
    always_comb
    begin
        state_next = state_reg;
        if (!tx_on)
        begin
            // Abort everything, including disable while active
            state_next = TX_IDLE;
        end
        else
        begin
            unique case (state_reg)
                TX_IDLE:
                begin
                    // Buffered data goes before a break
                    if (load)
                        state_next = TX_SHIFT;
                    else if (ctrl1_reg[C1_BREAK])
                        state_next = TX_BREAK;
                end
                TX_SHIFT:
                begin
                    // Last bit time ends the frame
                    if (tick && (bit_cnt_reg == 4'h1))
                        state_next = TX_IDLE;
                end
                TX_BREAK:
                begin
                    // Leave only after the least length and a cleared bit
                    if ((brk_cnt_reg >= BREAK_BITS) && !ctrl1_reg[C1_BREAK])
                        state_next = TX_IDLE;
                end
                default: state_next = TX_IDLE;
            endcase
        end
    end

    // Control register storage
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl1_reg <= CTRL1_RESET;
            ctrl2_reg <= CTRL2_RESET;
        end
        else
        begin
            ctrl1_reg <= ctrl1_next;
            ctrl2_reg <= ctrl2_next;
        end
    end

    // Configuration kept across disable
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            swm_reg <= 1'b0;
            div_hi_reg <= BYTE_RESET;
            div_lo_reg <= BYTE_RESET;
            fifo_ctrl_reg <= FIFO_CTRL_MASK & BYTE_RESET[5:0];
        end
        else if (wr)
        begin
            // Each writable register takes its own address
            if (addr == ADDR_CTRL3)
                swm_reg <= wdata[0];
            if (addr == ADDR_DIV_HI)
                div_hi_reg <= wdata;
            if (addr == ADDR_DIV_LO)
                div_lo_reg <= wdata;
            if (addr == ADDR_FIFO_CTRL)
                fifo_ctrl_reg <= wdata[5:0] & FIFO_CTRL_MASK;
        end
    end

    // Transmit buffer and sequencer state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tx_data_reg <= BYTE_RESET;
            data_full_reg <= 1'b0;
            state_reg <= TX_IDLE;
            baud_cnt_reg <= 16'h0000;
        end
        else
        begin
            if (data_wr)
                tx_data_reg <= wdata;
            data_full_reg <= data_full_next;
            state_reg <= state_next;
            baud_cnt_reg <= baud_cnt_next;
        end
    end

    // Shift register, least significant bit leaves first
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            shift_reg <= 12'hfff;
            bit_cnt_reg <= 4'h0;
        end
        else if (load)
        begin
            shift_reg <= frame;
            bit_cnt_reg <= frame_len;
        end
        else if ((state_reg == TX_SHIFT) && tick)
        begin
            shift_reg <= {1'b1, shift_reg[11:1]};
            bit_cnt_reg <= bit_cnt_reg - 4'h1;
        end
    end

    // Break length in whole bit times, saturating
    always_ff @(posedge clk)
    begin
        if (reset || (state_reg != TX_BREAK))
            brk_cnt_reg <= 4'h0;
        else if (tick && (brk_cnt_reg < BREAK_BITS))
            brk_cnt_reg <= brk_cnt_reg + 4'h1;
    end

    // Line level: frame bit, low for break, high when idle
    always_ff @(posedge clk)
    begin
        if (reset)
            tx_line_reg <= 1'b1;
        else if (state_next == TX_SHIFT)
            tx_line_reg <= load ? 1'b0 : (tick ? shift_reg[1] : shift_reg[0]);
        else
            tx_line_reg <= (state_next != TX_BREAK);
    end

    // Transmit flags and arms; a status read arms only a set flag
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tx_empty_reg <= 1'b1;
            tx_idle_reg <= 1'b1;
            empty_armed_reg <= 1'b0;
            idle_armed_reg <= 1'b0;
        end
        else
        begin
            tx_empty_reg <= tx_empty_next;
            tx_idle_reg <= tx_idle_next;
            if (status_rd)
            begin
                empty_armed_reg <= tx_empty_reg;
                idle_armed_reg <= tx_idle_reg;
            end
            else if (data_wr || !port_on)
            begin
                empty_armed_reg <= 1'b0;
                idle_armed_reg <= 1'b0;
            end
        end
    end

    // Receive status; disable clears it and marks the receiver idle
    always_ff @(posedge clk)
    begin
        if (reset || !port_on)
        begin
            rx_avail_reg <= 1'b0;
            overrun_reg <= 1'b0;
            perr_reg <= 1'b0;
            ferr_reg <= 1'b0;
            noise_reg <= 1'b0;
            rx_count_reg <= 3'h0;
            rx_idle_reg <= 1'b1;
            rx_armed_reg <= 1'b0;
        end
        else
        begin
            rx_idle_reg <= !rx_active;
            rx_avail_reg <= rx_store || (rx_avail_reg && !rx_clr);
            overrun_reg <= rx_over || (overrun_reg && !rx_clr);
            perr_reg <= (rx_store && rx_report.parity_err) || (perr_reg && !rx_clr);
            ferr_reg <= (rx_store && rx_report.framing_err) || (ferr_reg && !rx_clr);
            noise_reg <= (rx_store && rx_report.noise) || (noise_reg && !rx_clr);
            if (rx_store && (rx_count_reg != RX_COUNT_MAX))
                rx_count_reg <= rx_count_reg + 3'h1;
            else if (rx_clr)
                rx_count_reg <= 3'h0;
            if (status_rd)
                rx_armed_reg <= 1'b1;
            else if (data_rd || data_wr)
                rx_armed_reg <= 1'b0;
        end
    end

    // Received character holders
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rx_data_reg <= BYTE_RESET;
            rx_ninth_reg <= 1'b0;
        end
        else
        begin
            if (rx_store)
                rx_data_reg <= rx_byte;
            if (rx_ninth_take)
                rx_ninth_reg <= rx_report.bits[8];
        end
    end

    // Read selection; transmit ninth bit always reads zero
    logic [7:0] read_value;
    always_comb
    begin
        read_value = BYTE_RESET;
        unique case (addr)
            ADDR_STATUS: read_value = {perr_reg, noise_reg, ferr_reg, overrun_reg,
                                       rx_idle_reg, rx_avail_reg, tx_idle_reg, tx_empty_reg};
            ADDR_CTRL1: read_value = {ctrl1_reg[7:2], rx_ninth_reg, 1'b0};
            ADDR_CTRL2: read_value = ctrl2_reg;
            ADDR_CTRL3: read_value = {7'h00, swm_reg};
            ADDR_DATA: read_value = rx_data_reg;
            ADDR_DIV_HI: read_value = div_hi_reg;
            ADDR_DIV_LO: read_value = div_lo_reg;
            ADDR_FIFO_CTRL: read_value = {2'h0, fifo_ctrl_reg};
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_reg <= BYTE_RESET;
        else
            rdata_reg <= rd ? read_value : BYTE_RESET;
    end

    // Pin drive: both float while disabled
    wire shared_tx = port_on && swm_reg && ctrl2_reg[C2_TX_EN] && !ctrl2_reg[C2_RX_EN];
    assign tx_pin.oe = tx_on;
    assign tx_pin.out = tx_line_reg;
    assign shared_line_pin.oe = shared_tx;
    assign shared_line_pin.out = tx_line_reg;
    assign rx_line = rx_on ? shared_line_in : 1'b1;

    // Outputs toward the receiver and baud logic
    assign rdata = rdata_reg;
    assign receiver_enable = rx_on;
    assign single_wire_select = swm_reg;
    assign baud_divisor = divisor;
    assign fifo_control = fifo_ctrl_reg;
    assign irq_request = (ctrl2_reg[C2_IDLE_IRQ_EN] && tx_idle_reg)
                      || (ctrl2_reg[C2_EMPTY_IRQ_EN] && tx_empty_reg)
                      || (ctrl2_reg[C2_RX_IRQ_EN] && (rx_avail_reg || overrun_reg));

    // Idle falls only through the armed data write
    a_idle_clear_seq: assert property (@(posedge clk) disable iff (reset)
        $fell(tx_idle_reg) |-> $past(data_wr && idle_armed_reg))
        else $error("idle flag fell without status read and data write");

    // Idle never rises with work pending
    a_idle_not_queued: assert property (@(posedge clk) disable iff (reset)
        $rose(tx_idle_reg) |-> (state_reg == TX_IDLE) && !data_full_reg)
        else $error("idle flag rose while character queued");

    // Shifter load sets empty flag next cycle
    a_empty_on_load: assert property (@(posedge clk) disable iff (reset)
        load |=> tx_empty_reg && (state_reg == TX_SHIFT))
        else $error("empty flag not set after shifter load");

    // Empty falls only through the armed data write
    a_empty_clear_seq: assert property (@(posedge clk) disable iff (reset)
        $fell(tx_empty_reg) |-> $past(data_wr && empty_armed_reg && tx_on))
        else $error("empty flag fell without status read and data write");

    // Pins float while port disabled
    a_pins_float: assert property (@(posedge clk) disable iff (reset)
        !port_on |-> !tx_pin.oe && !shared_line_pin.oe)
        else $error("serial pin driven while port disabled");

    // Disable forces transmit enable off and flags high
    a_disable_reset: assert property (@(posedge clk) disable iff (reset)
        !port_on |=> !ctrl2_reg[C2_TX_EN] && tx_idle_reg && tx_empty_reg && !data_full_reg)
        else $error("port disable did not reset transmit state");

    // Break lasts at least the least length
    a_break_length: assert property (@(posedge clk) disable iff (reset)
        (state_reg == TX_BREAK) && (state_next == TX_IDLE) && tx_on
        |-> (brk_cnt_reg == BREAK_BITS) && !tx_line_reg)
        else $error("break ended before thirteen bit times");

    // Transmit pin driven only with both enables
    a_tx_pin_enable: assert property (@(posedge clk) disable iff (reset)
        tx_pin.oe |-> ctrl1_reg[C1_PORT_EN] && ctrl2_reg[C2_TX_EN])
        else $error("transmit pin driven without both enables");

endmodule

// ==== utx_pkg.sv ====
// Shared constants and carriers for the serial transmit control block
package utx_pkg;

    // Register index on the plain register port
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_CTRL2 = 3'h2;
    localparam logic [2:0] ADDR_CTRL3 = 3'h3;
    localparam logic [2:0] ADDR_DATA = 3'h4;
    localparam logic [2:0] ADDR_DIV_HI = 3'h5;
    localparam logic [2:0] ADDR_DIV_LO = 3'h6;
    localparam logic [2:0] ADDR_FIFO_CTRL = 3'h7;

    // serial_control_one field positions
    localparam int C1_PORT_EN = 7;
    localparam int C1_DATA_LEN = 6;
    localparam int C1_PAR_EN = 5;
    localparam int C1_PAR_HI = 4;
    localparam int C1_PAR_LO = 3;
    localparam int C1_BREAK = 2;
    localparam int C1_TX_NINTH = 0;

    // serial_control_two field positions
    localparam int C2_TX_EN = 7;
    localparam int C2_RX_EN = 6;
    localparam int C2_RX_IRQ_EN = 2;
    localparam int C2_IDLE_IRQ_EN = 1;
    localparam int C2_EMPTY_IRQ_EN = 0;

    // Bits that port disable clears, and bits software can write
    localparam logic [7:0] CTRL1_BREAK_MASK = 8'h04;
    localparam logic [7:0] CTRL1_WRITE_MASK = 8'hfd;
    localparam logic [7:0] CTRL2_DISABLE_MASK = 8'hc0;
    localparam logic [5:0] FIFO_CTRL_MASK = 6'h3f;

    // Reset values
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Frame lengths in bit times: start, data, two stop bits
    localparam logic [3:0] FRAME_BITS_8 = 4'hb;
    localparam logic [3:0] FRAME_BITS_9 = 4'hc;
    // Least break length in bit times
    localparam logic [3:0] BREAK_BITS = 4'hd;
    localparam logic [2:0] RX_COUNT_MAX = 3'h7;

    // Transmit sequencer states, Gray along idle-shift-break
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01,
        TX_BREAK = 2'b11
    } utx_state_type;

    // Character handed over by the receiver
    typedef struct packed {
        logic valid;
        logic [8:0] bits;
        logic parity_err;
        logic framing_err;
        logic noise;
    } utx_rx_report_type;

    // Drive of one pin: level and enable
    typedef struct packed {
        logic out;
        logic oe;
    } utx_pin_drive_type;

    // Parity by type: even, odd, mark, space
    function automatic logic utx_parity(input logic [7:0] bits, input logic [1:0] kind);
        logic result;
        result = 1'b0;
        case (kind)
            2'b00: result = ^bits;
            2'b01: result = ~^bits;
            2'b10: result = 1'b1;
            default: result = 1'b0;
        endcase
        return result;
    endfunction

endpackage

// ==== utx_line_partner.sv ====
`timescale 1ns/1ps
// Remote receiver on the transmit wire, sampling each bit mid-way
module utx_line_partner
(
    input wire logic clk,
    input wire logic line,
    input wire logic [15:0] div,
    input wire logic [3:0] nbits,
    output logic [8:0] word,
    output int frames,
    output int low_max
);
    int low_run; // Current low stretch in cycles
    // Longest low stretch, taken as a break when beyond a frame
    initial
    begin
        low_run = 0;
        low_max = 0;
        forever
        begin
            @(posedge clk);
            low_run = (line === 1'b0) ? low_run + 1 : 0;
            if (low_run > low_max)
                low_max = low_run;
        end
    end
    // Frame receiver: start bit, data bits, then wait for a high line
    initial
    begin
        word = '0;
        frames = 0;
        forever
        begin
            @(posedge clk);
            if (line === 1'b0)
            begin
                repeat (div / 2) @(posedge clk);
                word = '0;
                for (int i = 0; i < nbits; i++)
                begin
                    repeat (div) @(posedge clk);
                    word[i] = line;
                end
                repeat (div) @(posedge clk);
                // A break keeps the line low past the stop position
                while (line !== 1'b1)
                    @(posedge clk);
                frames++;
            end
        end
    end
endmodule

// ==== utx_top_test.sv ====
`timescale 1ns/1ps
// Register-level bench for the serial transmit control block
module utx_top_test;
    import utx_pkg::*;
    localparam int DIV = 4; // Cycles per bit
    logic clk;
    logic reset;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    utx_pin_drive_type tx_pin;
    utx_pin_drive_type shared_line_pin;
    logic irq_request;
    logic line; // Transmit wire, pulled up when floating
    logic [3:0] nbits; // Data bits per frame at the far end
    logic [8:0] word;
    int frames;
    int low_max;
    int error_cnt;
    int checks;
    logic [7:0] v; // Last value read
    utx_rx_report_type rx_rep; // Injected receiver report
    logic rx_ln; // Gated receive line
    logic rx_en; // Receiver enable
    logic swm; // Single-wire select
    logic [15:0] baud_div; // Divisor out
    logic [5:0] fifo_ctl; // FIFO control out
    assign line = tx_pin.oe ? tx_pin.out : 1'b1;
    utx_top dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rx_report(rx_rep), .rx_active(1'b0), .shared_line_in(1'b0),
        .tx_pin(tx_pin), .shared_line_pin(shared_line_pin), .rx_line(rx_ln),
        .receiver_enable(rx_en), .single_wire_select(swm), .baud_divisor(baud_div),
        .fifo_control(fifo_ctl), .irq_request(irq_request));
    utx_line_partner far (.clk(clk), .line(line), .div(16'h0004), .nbits(nbits),
        .word(word), .frames(frames), .low_max(low_max));
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever
            #2 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Counts, verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One register write, settled on return
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // One register read, data taken in the following cycle
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // Even, odd, mark, space
    function automatic logic par(input logic [7:0] b, input logic [1:0] k);
        return (k == 2'b00) ? ^b : (k == 2'b01) ? ~^b : (k == 2'b10);
    endfunction
    // Queue one character and check what the far end saw
    task automatic send(input logic [7:0] d, input logic [8:0] exp);
        int f0;
        int i;
        rd_reg(ADDR_STATUS);
        f0 = frames;
        wr_reg(ADDR_DATA, d);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v & 8'h02}, 9'h000);
        for (i = 0; i < 600 && frames == f0; i++)
            @(posedge clk);
        if (frames == f0)
        begin
            error_cnt++;
            $display("[FAIL] %0t no frame seen", $time);
            end_sim();
        end
        chk(word, exp);
        repeat (3 * DIV) @(posedge clk);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h00b);
    endtask
    // One receiver report, one cycle long
    task automatic rx_pulse(input logic [8:0] b);
        @(posedge clk);
        rx_rep <= {1'b1, b, 3'b000};
        @(posedge clk);
        rx_rep <= '0;
    endtask
    // Receive one character in a format and check the holders
    task automatic rx_one(input logic [7:0] c1, input logic [8:0] b, input logic [7:0] ed,
        input logic [7:0] ec);
        wr_reg(ADDR_CTRL1, c1);
        rx_pulse(b);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h00f);
        rd_reg(ADDR_DATA);
        chk({1'b0, v}, {1'b0, ed});
        rd_reg(ADDR_CTRL1);
        chk({1'b0, v}, {1'b0, ec});
    endtask
    // Main sequence
    initial
    begin
        reset = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        rx_rep = '0;
        nbits = 4'h8;
        error_cnt = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h00b);
        rd_reg(ADDR_CTRL1);
        chk({1'b0, v}, 9'h000);
        rd_reg(ADDR_CTRL2);
        chk({1'b0, v}, 9'h000);
        $display("reset test done");
        wr_reg(ADDR_DIV_LO, 8'h04);
        wr_reg(ADDR_FIFO_CTRL, 8'hff);
        chk({3'h0, fifo_ctl}, 9'h03f);
        wr_reg(ADDR_CTRL1, 8'h83);
        rd_reg(ADDR_CTRL1);
        chk({1'b0, v}, 9'h080);
        chk({8'h00, tx_pin.oe}, 9'h000);
        wr_reg(ADDR_CTRL2, 8'h81);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h00b);
        chk({7'h00, tx_pin.oe, irq_request}, 9'h003);
        wr_reg(ADDR_CTRL3, 8'h01);
        chk({7'h00, swm, shared_line_pin.oe}, 9'h003);
        wr_reg(ADDR_CTRL3, 8'h00);
        $display("enable test done");
        wr_reg(ADDR_CTRL1, 8'h80);
        send(8'hd3, 9'h0d3);
        for (int b = 0; b < 2; b++)
            for (int k = 0; k < 4; k++)
            begin
                nbits = b ? 4'h9 : 4'h8;
                wr_reg(ADDR_CTRL1, 8'ha0 | 8'(b << 6) | 8'(k << 3));
                send(8'he9, b ? {par(8'he9, 2'(k)), 8'he9}
                    : {1'b0, par(8'h69, 2'(k)), 7'h69});
            end
        wr_reg(ADDR_CTRL1, 8'hc1);
        send(8'h35, 9'h135);
        $display("format test done");
        nbits = 4'h8;
        wr_reg(ADDR_CTRL1, 8'h80);
        rd_reg(ADDR_STATUS);
        wr_reg(ADDR_DATA, 8'h11);
        rd_reg(ADDR_STATUS);
        wr_reg(ADDR_DATA, 8'h22);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h008);
        repeat (5 * DIV) @(posedge clk);
        wr_reg(ADDR_CTRL2, 8'h01);
        chk({8'h00, tx_pin.oe}, 9'h000);
        repeat (15 * DIV) @(posedge clk);
        wr_reg(ADDR_CTRL2, 8'h81);
        send(8'ha5, 9'h0a5);
        $display("abort test done");
        wr_reg(ADDR_DATA, 8'h00);
        repeat (5 * DIV) @(posedge clk);
        wr_reg(ADDR_CTRL1, 8'h74);
        rd_reg(ADDR_CTRL1);
        chk({1'b0, v}, 9'h070);
        rd_reg(ADDR_CTRL2);
        chk({1'b0, v}, 9'h001);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h00b);
        chk({7'h00, tx_pin.oe, shared_line_pin.oe}, 9'h000);
        chk({3'h0, fifo_ctl}, 9'h03f);
        wr_reg(ADDR_CTRL2, 8'h81);
        rd_reg(ADDR_CTRL2);
        chk({1'b0, v}, 9'h001);
        $display("disable test done");
        repeat (15 * DIV) @(posedge clk);
        wr_reg(ADDR_CTRL1, 8'h80);
        wr_reg(ADDR_CTRL2, 8'h81);
        wr_reg(ADDR_CTRL1, 8'h84);
        wr_reg(ADDR_CTRL1, 8'h80);
        repeat (10 * DIV) @(posedge clk);
        chk({8'h00, line}, 9'h000);
        repeat (5 * DIV) @(posedge clk);
        chk({8'h00, line}, 9'h001);
        wr_reg(ADDR_CTRL1, 8'h84);
        repeat (30 * DIV) @(posedge clk);
        chk({8'h00, line}, 9'h000);
        wr_reg(ADDR_CTRL1, 8'h80);
        repeat (4 * DIV) @(posedge clk);
        chk({8'h00, line}, 9'h001);
        chk({8'h00, low_max >= 30 * DIV}, 9'h001);
        $display("break test done");
        wr_reg(ADDR_CTRL2, 8'hc1);
        chk({7'h00, rx_en, rx_ln}, 9'h002);
        rx_one(8'he0, 9'h1a5, 8'ha5, 8'he0);
        rx_one(8'hc0, 9'h15a, 8'h5a, 8'hc2);
        rx_one(8'ha0, 9'h0da, 8'h5a, 8'ha2);
        rx_pulse(9'h000);
        rx_pulse(9'h000);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h01f);
        wr_reg(ADDR_CTRL1, 8'h00);
        rd_reg(ADDR_STATUS);
        chk({1'b0, v}, 9'h00b);
        chk({7'h00, rx_en, rx_ln}, 9'h001);
        chk(baud_div[8:0], 9'h004);
        $display("receive test done");
        end_sim();
    end
endmodule
